// file: inc/adcsq_pkg.sv
// Constants shared by the converter sequencer design files
package adcsq_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 250;
  localparam int T_SYNC_US   = 30;
  localparam int T_STEP_US   = 40;
  localparam int SYNC_CYC    = T_SYNC_US * CLK_MHZ;
  localparam int STEP_CYC    = T_STEP_US * CLK_MHZ;
  localparam int TMR_W       = 20;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int RES_W       = 10;
  localparam int SLOTS       = 8;
  localparam int PAIR_W      = 2 * RES_W;
  localparam logic [3:0] RST_DLY_SEL = 4'h0;
  localparam logic       RST_LOOP    = 1'b0;

  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CH_BATT_V   = 4'h0;
  localparam logic [3:0] CH_BATT_I   = 4'h1;
  localparam logic [3:0] CH_APP_SUP  = 4'h2;
  localparam logic [3:0] CH_DIE_TEMP = 4'h3;
  localparam logic [3:0] CH_RSV_A    = 4'h4;
  localparam logic [3:0] CH_BUS_V    = 4'h5;
  localparam logic [3:0] CH_RSV_B    = 4'h6;
  localparam logic [3:0] CH_RSV_C    = 4'h7;
  localparam logic [3:0] CH_COIN     = 4'h8;
  localparam logic [3:0] CH_TOUCH_XF = 4'hc;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_CAL  = 3'b000,
    S_IDLE = 3'b001,
    S_SYNC = 3'b010,
    S_DLY1 = 3'b011,
    S_CONV = 3'b100,
    S_GAP  = 3'b101,
    S_LOOP = 3'b110
  } adcsq_state_e;

endpackage

// file: inc/adcsq_tmr_if.sv
// Handshake between the sequencer and its delay timer
`timescale 1ns/1ps
interface adcsq_tmr_if #(parameter int W = 20);
  logic         load;
  logic [W-1:0] cycles;
  logic         done;
  logic         busy;

  modport ctl (output load, output cycles, input done, input busy);
  modport tmr (input load, input cycles, output done, output busy);
endinterface

// file: src/adcsq_timer.sv
// Down-counting delay timer for the sequencer wait phases
`timescale 1ns/1ps
module adcsq_timer
  import adcsq_pkg::*;
#(
  parameter int W = TMR_W
)
(
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  adcsq_tmr_if.tmr  tif
);

  logic [W-1:0] cnt_q;
  logic         run_q;
  logic         done_q;

  // Load, count down, pulse done for one cycle at zero
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end
    else if (tif.load)
    begin
      cnt_q  <= tif.cycles;
      run_q  <= 1'b1;
      done_q <= 1'b0;
    end
    else if (run_q && cnt_q == '0)
    begin
      run_q  <= 1'b0;
      done_q <= 1'b1;
    end
    else
    begin
      cnt_q  <= run_q ? cnt_q - 1'b1 : cnt_q;
      done_q <= 1'b0;
    end
  end

  assign tif.done = done_q;
  assign tif.busy = run_q;

endmodule

// file: src/adcsq_top.sv
// Conversion sequencer for the 16-channel 10-bit converter
`timescale 1ns/1ps
module adcsq_top
  import adcsq_pkg::*;
#(
  parameter int SYNC_CYCLES = SYNC_CYC,
  parameter int STEP_CYCLES = STEP_CYC
)
(
  input  wire logic                 I_SYS_CLK,
  input  wire logic                 I_NRST,
  input  wire logic                 I_CONVERTER_ENABLE_BIT,
  input  wire logic                 I_SEQUENCE_TRIGGER,
  input  wire logic [3:0]           I_START_DELAY_SEL,
  input  wire logic [3:0]           I_INTER_CONV_DELAY_SEL,
  input  wire logic [3:0]           I_LOOP_END_DELAY_SEL,
  input  wire logic                 I_LOOP_MODE,
  input  wire logic                 I_RESULT_FREEZE,
  input  wire logic                 I_SEQ_DONE_MASK,
  input  wire logic [2:0]           I_LAST_SLOT_INDEX,
  input  wire logic [4*SLOTS-1:0]   I_SLOT_CHANNEL_SEL,
  input  wire logic                 I_CAL_DONE,
  input  wire logic                 I_CONV_DONE,
  input  wire logic [RES_W-1:0]     I_CONV_DATA,
  output logic                      O_CORE_POWER_EN,
  output logic                      O_CAL_START,
  output logic                      O_CONV_START,
  output logic [15:0]               O_MUX_SEL,
  output logic                      O_SEQUENCE_TRIGGER,
  output logic                      O_SEQ_BUSY,
  output logic                      O_SEQ_DONE_IRQ,
  output logic [PAIR_W-1:0]         O_SLOT_RESULT0,
  output logic [PAIR_W-1:0]         O_SLOT_RESULT1,
  output logic [PAIR_W-1:0]         O_SLOT_RESULT2,
  output logic [PAIR_W-1:0]         O_SLOT_RESULT3
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Reserved codes have no input behind them
  function automatic logic chan_rsv(input logic [3:0] c);
    chan_rsv = (c == CH_RSV_A) || (c == CH_RSV_B) || (c == CH_RSV_C);
  endfunction
  // Delay code times the step length, in clock cycles
  function automatic logic [TMR_W-1:0] dly_cyc(input logic [3:0] c);
    dly_cyc = TMR_W'(int'(c) * STEP_CYCLES);
  endfunction

  adcsq_tmr_if #(.W(TMR_W)) tif ();
  adcsq_timer #(.W(TMR_W)) u_timer (
    .i_sys_clk (I_SYS_CLK),
    .i_nrst    (I_NRST),
    .tif       (tif)
  );
  adcsq_state_e      st_q;
  logic [2:0]        slot_q;
  logic              issued_q;
  logic              trig_q;
  logic              load_q;
  logic [TMR_W-1:0]  cyc_q;
  logic [3:0]        dly1_q;
  logic [3:0]        dly2_q;
  logic [3:0]        dly3_q;
  logic              loop_q;
  logic              en_q;
  logic [RES_W-1:0]  work_q [SLOTS];
  logic [3:0]        chan;
  logic              slot_end;
  logic              pass_end;
  logic              accept;
  logic [RES_W-1:0]  last_val;
  logic [RES_W-1:0]  pub [SLOTS];

  // ----------------------------------------------------------------
  // Configuration shadow
  // ----------------------------------------------------------------
  // Delay and loop settings start from zero after reset
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      dly1_q <= RST_DLY_SEL;
      dly2_q <= RST_DLY_SEL;
      dly3_q <= RST_DLY_SEL;
      loop_q <= RST_LOOP;
      en_q   <= 1'b0;
    end
    else
    begin
      dly1_q <= I_START_DELAY_SEL;
      dly2_q <= I_INTER_CONV_DELAY_SEL;
      dly3_q <= I_LOOP_END_DELAY_SEL;
      loop_q <= I_LOOP_MODE;
      en_q   <= I_CONVERTER_ENABLE_BIT;
    end
  end

  // Current slot's channel code and end-of-slot decode
  assign chan     = I_SLOT_CHANNEL_SEL[4*slot_q +: 4];
  assign slot_end = (st_q == S_CONV) && en_q &&
                    (chan_rsv(chan) || (issued_q && I_CONV_DONE));
  assign pass_end = slot_end && (slot_q == I_LAST_SLOT_INDEX);
  assign accept   = (st_q == S_IDLE) && en_q && trig_q;
  assign last_val = chan_rsv(chan) ? '0 : I_CONV_DATA;

  // ----------------------------------------------------------------
  // Trigger bit
  // ----------------------------------------------------------------
  // Set by a write while enabled, cleared on accept; a new write wins
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
      trig_q <= 1'b0;
    else if (I_SEQUENCE_TRIGGER && I_CONVERTER_ENABLE_BIT)
      trig_q <= 1'b1;
    else if (accept || !en_q)
      trig_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  // Calibrate first, then run slot 0 to the stop slot with delays
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      st_q     <= S_CAL;
      slot_q   <= 3'h0;
      issued_q <= 1'b0;
      load_q   <= 1'b0;
      cyc_q    <= '0;
    end
    else if (!en_q && st_q != S_CAL)
    begin
      st_q     <= S_IDLE;
      issued_q <= 1'b0;
      load_q   <= 1'b0;
    end
    else
    begin
      load_q <= 1'b0;
      case (st_q)
        S_CAL:
          if (I_CAL_DONE)
            st_q <= S_IDLE;
        S_IDLE:
          if (accept)
          begin
            st_q   <= S_SYNC;
            slot_q <= 3'h0;
            load_q <= 1'b1;
            cyc_q  <= TMR_W'(SYNC_CYCLES);
          end
        S_SYNC:
          if (tif.done)
          begin
            st_q   <= S_DLY1;
            load_q <= 1'b1;
            cyc_q  <= dly_cyc(dly1_q);
          end
        S_CONV:
          if (pass_end)
          begin
            issued_q <= 1'b0;
            slot_q   <= 3'h0;
            st_q     <= loop_q ? S_LOOP : S_IDLE;
            load_q   <= loop_q;
            cyc_q    <= dly_cyc(dly3_q);
          end
          else if (slot_end)
          begin
            issued_q <= 1'b0;
            slot_q   <= slot_q + 3'h1;
            st_q     <= S_GAP;
            load_q   <= 1'b1;
            cyc_q    <= dly_cyc(dly2_q);
          end
          else
            issued_q <= 1'b1;
        S_DLY1, S_GAP, S_LOOP:
          if (tif.done)
            st_q <= S_CONV;
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  assign tif.load   = load_q;
  assign tif.cycles = cyc_q;

  // ----------------------------------------------------------------
  // Core control outputs
  // ----------------------------------------------------------------
  // Power, calibration, conversion start and one-hot input select
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_CORE_POWER_EN <= 1'b0;
      O_CAL_START     <= 1'b0;
      O_CONV_START    <= 1'b0;
      O_MUX_SEL       <= 16'h0000;
      O_SEQ_BUSY      <= 1'b0;
    end
    else
    begin
      O_CORE_POWER_EN <= (st_q == S_CAL) || en_q;
      O_CAL_START     <= (st_q == S_CAL) && !I_CAL_DONE;
      O_CONV_START    <= (st_q == S_CONV) && en_q && !issued_q &&
                         !chan_rsv(chan);
      // Codes 0-3, 5, 8-15 select their sensed signal; 4, 6, 7 none
      O_MUX_SEL       <= (st_q == S_CONV && !chan_rsv(chan)) ?
                         16'h0001 << chan : 16'h0000;
      O_SEQ_BUSY      <= (st_q != S_IDLE) && (st_q != S_CAL);
    end
  end

  // ----------------------------------------------------------------
  // Results and completion event
  // ----------------------------------------------------------------
  // Slot results collect here; reserved slots store zero
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      for (int i = 0; i < SLOTS; i++)
        work_q[i] <= '0;
    end
    else if (slot_end)
      work_q[slot_q] <= last_val;
  end
  // Final slot joins the stored ones on the way out
  always_comb
    for (int i = 0; i < SLOTS; i++)
      pub[i] = (3'(i) == slot_q) ? last_val : work_q[i];

  // Publish two slots per result word at pass end unless held
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_SLOT_RESULT0 <= '0;
      O_SLOT_RESULT1 <= '0;
      O_SLOT_RESULT2 <= '0;
      O_SLOT_RESULT3 <= '0;
    end
    else if (pass_end && !I_RESULT_FREEZE)
    begin
      O_SLOT_RESULT0 <= {pub[1], pub[0]};
      O_SLOT_RESULT1 <= {pub[3], pub[2]};
      O_SLOT_RESULT2 <= {pub[5], pub[4]};
      O_SLOT_RESULT3 <= {pub[7], pub[6]};
    end
  end

  // Done pulse and trigger readback
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_SEQ_DONE_IRQ     <= 1'b0;
      O_SEQUENCE_TRIGGER <= 1'b0;
    end
    else
    begin
      O_SEQ_DONE_IRQ     <= pass_end && !I_SEQ_DONE_MASK;
      O_SEQUENCE_TRIGGER <= trig_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  adcsq_state_e     pst_q;
  logic [TMR_W:0]   dwell_q;
  // Cycles spent in the present state, for delay length checks
  always_ff @(posedge I_SYS_CLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pst_q   <= S_CAL;
      dwell_q <= '0;
    end
    else
    begin
      pst_q   <= st_q;
      dwell_q <= (st_q == pst_q) ? dwell_q + 1'b1 : (TMR_W+1)'(1);
    end
  end
  sequence seq_accept;
    st_q == S_IDLE && en_q && trig_q;
  endsequence
  sequence seq_sync_run;
    st_q == S_SYNC ##1 st_q == S_SYNC;
  endsequence
  chk_irq_cause: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    O_SEQ_DONE_IRQ |-> $past(pass_end) && !$past(I_SEQ_DONE_MASK))
    else $error("done event without unmasked pass end");
  chk_cal_exit: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    st_q == S_CAL && I_CAL_DONE |=> st_q == S_IDLE ##1 !O_CAL_START)
    else $error("calibration did not finish cleanly");
  chk_power_off: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    !en_q && st_q != S_CAL |=> !O_CORE_POWER_EN && !O_CONV_START)
    else $error("core powered while disabled");
  chk_accept_seq: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    seq_accept |=> seq_sync_run ##0 slot_q == 3'h0)
    else $error("accepted trigger did not start sync");
  chk_sync_len: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    st_q == S_SYNC && tif.done |-> dwell_q == (TMR_W+1)'(SYNC_CYCLES + 2))
    else $error("sync period length wrong");
  chk_gap_len: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    st_q == S_GAP && tif.done
      |-> dwell_q == (TMR_W+1)'(int'(dly2_q) * STEP_CYCLES + 2))
    else $error("inter conversion delay length wrong");
  chk_slot_bound: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    st_q == S_CONV |-> slot_q <= I_LAST_SLOT_INDEX)
    else $error("slot beyond stop index");
  chk_freeze_hold: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    I_RESULT_FREEZE |=> $stable(O_SLOT_RESULT0) && $stable(O_SLOT_RESULT3))
    else $error("results changed while held");
  chk_trig_ignore: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    I_SEQUENCE_TRIGGER && !I_CONVERTER_ENABLE_BIT && !trig_q
      |=> !trig_q)
    else $error("trigger taken while disabled");
  chk_trig_clear: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    seq_accept and !I_SEQUENCE_TRIGGER |=> !trig_q)
    else $error("trigger bit not cleared on accept");
  chk_loop_restart: assert property (@(posedge I_SYS_CLK) disable iff (!I_NRST)
    st_q == S_LOOP && en_q && tif.done |=> st_q == S_CONV && slot_q == 3'h0)
    else $error("loop did not restart at slot zero");

endmodule

// file: dv/adcsq_core_model.sv
// Behavioural model of the converter core behind the sequencer
`timescale 1ns/1ps
module adcsq_core_model
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_cal_start,
  input  wire logic       i_conv_start,
  input  wire logic [15:0] i_mux_sel,
  input  wire logic       i_slow,
  output logic            o_cal_done,
  output logic            o_conv_done,
  output logic [9:0]      o_conv_data
);
  logic [3:0] cal_cnt_q;
  logic [3:0] left_q;
  logic [9:0] code_q;

  // Code is channel in top bits; a select that is not one-hot gives all ones
  function automatic logic [9:0] code_of(input logic [15:0] sel);
    logic [9:0] c;
    c = 10'h3ff;
    for (int i = 0; i < 16; i++)
    begin
      if (sel === (16'h1 << i))
      begin
        c = {i[3:0], 6'h2a};
      end
    end
    return c;
  endfunction

  // Calibration answer and conversion answer, prompt or slow
  always_ff @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cal_cnt_q   <= 4'h0;
      left_q      <= 4'h0;
      code_q      <= 10'h000;
      o_cal_done  <= 1'b0;
      o_conv_done <= 1'b0;
      o_conv_data <= 10'h155;
    end
    else
    begin
      o_cal_done  <= 1'b0;
      o_conv_done <= 1'b0;
      o_conv_data <= ~o_conv_data;  // Line only valid with done
      cal_cnt_q   <= i_cal_start ? cal_cnt_q + 4'h1 : 4'h0;
      if (i_cal_start && cal_cnt_q == 4'h5)
      begin
        o_cal_done <= 1'b1;
        cal_cnt_q  <= 4'h0;
      end
      if (i_conv_start)
      begin
        code_q <= code_of(i_mux_sel);
        left_q <= i_slow ? 4'h9 : 4'h2;
      end
      else if (left_q != 4'h0)
      begin
        left_q <= left_q - 4'h1;
        if (left_q == 4'h1)
        begin
          o_conv_done <= 1'b1;
          o_conv_data <= code_q;
        end
      end
    end
  end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module testbench;
  import adcsq_pkg::*;
  localparam int STP = 4;
  logic clk = 1'b0, nrst = 1'b0, en = 1'b0, trg = 1'b0;
  logic [3:0] d1 = 4'h0, d2 = 4'h0, d3 = 4'h0;
  logic loopm = 1'b0, frz = 1'b0, msk = 1'b0, slow = 1'b0;
  logic [2:0] last = 3'h7;
  logic [3:0] chs [8];
  logic [31:0] sel;
  logic cal_done, conv_done, pwr, cal_st, cst, otrig, busy, irq;
  logic [9:0] data;
  logic [15:0] mux;
  logic [19:0] rw [4];
  int n_fail = 0, n_tests = 0, n_irq = 0, cyc = 0, t0, f0, g0, l0;
  int ts[$];

  always #2 clk = ~clk;
  always_comb for (int k = 0; k < 8; k++) sel[4*k +: 4] = chs[k];

  adcsq_top #(.SYNC_CYCLES(5), .STEP_CYCLES(STP)) DUT (
    .I_SYS_CLK(clk), .I_NRST(nrst), .I_CONVERTER_ENABLE_BIT(en),
    .I_SEQUENCE_TRIGGER(trg), .I_START_DELAY_SEL(d1),
    .I_INTER_CONV_DELAY_SEL(d2), .I_LOOP_END_DELAY_SEL(d3),
    .I_LOOP_MODE(loopm), .I_RESULT_FREEZE(frz), .I_SEQ_DONE_MASK(msk),
    .I_LAST_SLOT_INDEX(last), .I_SLOT_CHANNEL_SEL(sel),
    .I_CAL_DONE(cal_done), .I_CONV_DONE(conv_done), .I_CONV_DATA(data),
    .O_CORE_POWER_EN(pwr), .O_CAL_START(cal_st), .O_CONV_START(cst),
    .O_MUX_SEL(mux), .O_SEQUENCE_TRIGGER(otrig), .O_SEQ_BUSY(busy),
    .O_SEQ_DONE_IRQ(irq), .O_SLOT_RESULT0(rw[0]), .O_SLOT_RESULT1(rw[1]),
    .O_SLOT_RESULT2(rw[2]), .O_SLOT_RESULT3(rw[3]));

  adcsq_core_model core (
    .i_sys_clk(clk), .i_nrst(nrst), .i_cal_start(cal_st),
    .i_conv_start(cst), .i_mux_sel(mux), .i_slow(slow),
    .o_cal_done(cal_done), .o_conv_done(conv_done), .o_conv_data(data));

  // Cycle stamps of conversion starts and count of done events
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cst === 1'b1) ts.push_back(cyc);
    if (irq === 1'b1) n_irq++;
  end

  // Expected result of one slot: reserved inputs store zero
  function automatic logic [9:0] ex(input logic [3:0] c);
    return (c == 4'h4 || c == 4'h6 || c == 4'h7) ? 10'h0 : {c, 6'h2a};
  endfunction

  task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_res(input int n);
    logic [9:0] got;
    for (int k = 0; k < n; k++)
    begin
      got = rw[k/2][10*(k%2) +: 10];
      cmp({10'h0, got}, {10'h0, ex(chs[k])});
    end
  endtask

  task automatic trig();
    ts.delete();
    @(posedge clk) trg <= 1'b1;
    t0 = cyc;
    @(posedge clk) trg <= 1'b0;
  endtask

  task automatic wait_idle();
    repeat (6) @(posedge clk);
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic run_loop();
    loopm <= 1'b1;
    repeat (2) @(posedge clk);
    trig();
    for (int i = 0; i < 3000 && ts.size() < 4; i++) @(posedge clk);
    loopm <= 1'b0;
    wait_idle();
  endtask

  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    finish_test();
  end

  initial
  begin
    chs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hc, 4'hf};
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    cmp(cal_st, 1'b1);
    cmp(rw[0], 20'h0);
    for (int i = 0; i < 200 && cal_st !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    cmp(pwr, 1'b0);
    // Trigger while disabled is dropped
    trig();
    repeat (40) @(posedge clk);
    cmp(ts.size(), 0);
    cmp(n_irq, 0);
    cmp(busy, 1'b0);
    // Full eight-slot pass over valid codes
    en <= 1'b1;
    repeat (4) @(posedge clk);
    cmp(pwr, 1'b1);
    trig();
    wait_idle();
    cmp(ts.size(), 8);
    chk_res(8);
    cmp(n_irq, 1);
    cmp(otrig, 1'b0);
    f0 = ts[0] - t0;
    g0 = ts[1] - ts[0];
    // Stop index 010 with start and gap delays
    chs[0] <= 4'ha;
    chs[1] <= 4'hb;
    chs[2] <= 4'hd;
    d1 <= 4'h3;
    d2 <= 4'h2;
    last <= 3'h2;
    repeat (3) @(posedge clk);
    trig();
    wait_idle();
    cmp(ts.size(), 3);
    cmp(ts[0] - t0 - f0, 3 * STP);
    cmp(ts[1] - ts[0] - g0, 2 * STP);
    chk_res(3);
    cmp(n_irq, 2);
    // Reserved channels, masked event, slow core
    chs[0] <= 4'h4;
    chs[1] <= 4'h5;
    chs[2] <= 4'h6;
    msk <= 1'b1;
    slow <= 1'b1;
    repeat (3) @(posedge clk);
    trig();
    wait_idle();
    cmp(ts.size(), 1);
    chk_res(3);
    cmp(n_irq, 2);
    // Loop with results held
    chs[0] <= 4'h9;
    chs[1] <= 4'h8;
    msk <= 1'b0;
    slow <= 1'b0;
    frz <= 1'b1;
    d2 <= 4'h0;
    last <= 3'h1;
    run_loop();
    cmp(ts.size() >= 4, 1'b1);
    cmp(rw[0], {ex(4'h5), 10'h0});
    l0 = ts[2] - ts[1];
    // Loop with end delay and results released
    frz <= 1'b0;
    d3 <= 4'h2;
    run_loop();
    cmp(ts[2] - ts[1] - l0, 2 * STP);
    chk_res(2);
    finish_test();
  end
endmodule
